// ===== rtl/psf_device.sv
// Sample buffer end: 32-entry store of 18-bit samples with indexed register access.
// Assumes samples arrive from the measurement logic on the same clock, with valid/ready.
`timescale 1ns/10ps
`default_nettype none
module psf_device (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Register link.
   psf_link_if.device link,
   // Sample source from the measurement logic.
   input wire logic sample_valid_in,
   input wire logic [17:0] sample_data_in,
   input wire logic sample_emitter2_in,
   output logic sample_ready_out,
   input wire logic dual_emitter_mode_in,
   // Status.
   output logic almost_full_out,
   output logic [5:0] fill_level_out
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [17:0] mem [0:psf_pkg::DEPTH-1];  // Sample store.
   logic [7:0] config_r;                   // Rollover and threshold.
   logic [4:0] wr_index_r;                 // Next entry to fill.
   logic [4:0] rd_index_r;                 // Entry at the data port.
   logic [3:0] lost_r;                     // Overwrite counter.
   logic [5:0] level_r;                    // Unread entries.
   logic [7:0] trim1_r;                    // Emitter 1 gain trim.
   logic [7:0] trim2_r;                    // Emitter 2 gain trim.
   psf_pkg::psf_phase_type phase_r;        // Byte phase of readout.
   // Two-entry skid buffer between source and the scaler.
   logic [18:0] skid_data_r [0:1];
   logic [1:0] skid_cnt_r;
   logic skid_wptr_r;
   logic skid_rptr_r;
   logic skid_pop;
   logic [18:0] head;
   logic [17:0] scaled;
   logic [26:0] product;                   // Full 18 by 9 bit product, so no carry is lost before the shift.
   logic [7:0] trim_sel;
   logic full;
   logic store;
   logic overwrite;
   logic host_wr;
   logic host_rd_data;
   logic [3:0] empties;

   // Decode of a host write to one address.
   function automatic logic is_write(input logic [7:0] a);
      is_write = link.req && link.wr && (link.addr == a);
   endfunction : is_write

   // ------------------------------------------------------------------
   // Skid buffer: stalls the source only when both entries hold data.
   // ------------------------------------------------------------------
   assign sample_ready_out = (skid_cnt_r != 2'h2);
   assign head = skid_data_r[skid_rptr_r];
   assign skid_pop = (skid_cnt_r != 2'h0);

   // Buffer write side and occupancy count.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         skid_cnt_r <= 2'h0;
         skid_wptr_r <= 1'b0;
         skid_rptr_r <= 1'b0;
      end else begin
         if (sample_valid_in && sample_ready_out) begin
            skid_data_r[skid_wptr_r] <= {sample_emitter2_in, sample_data_in};
            skid_wptr_r <= ~skid_wptr_r;
         end
         if (skid_pop) begin
            skid_rptr_r <= ~skid_rptr_r;
         end
         skid_cnt_r <= skid_cnt_r + {1'b0, sample_valid_in && sample_ready_out} - {1'b0, skid_pop};
      end
   end

   // ------------------------------------------------------------------
   // Gain scaling and store decision.
   // ------------------------------------------------------------------
   // Trim zero means unity; otherwise scale by (256+trim)/256 and clip.
   // In dual mode the emitter flag picks the second trim for samples flagged as emitter 2.
   assign trim_sel = (dual_emitter_mode_in && head[18]) ? trim2_r : trim1_r;
   assign product = (27'(head[17:0]) * 27'({1'b1, trim_sel})) >> 8;
   // Saturation keeps the value within the 18-bit field.
   assign scaled = (product[26:18] != 9'h000) ? 18'h3ffff : product[17:0];
   assign full = (level_r == psf_pkg::DEPTH_COUNT);
   assign store = skid_pop && (!full || config_r[psf_pkg::ROLLOVER_BIT]);
   assign overwrite = skid_pop && full && config_r[psf_pkg::ROLLOVER_BIT];

   // Sample store write; reset clears every entry, so the data port reads zero after reset.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < psf_pkg::DEPTH; i++) begin
            mem[i] <= 18'h00000;
         end
      end else if (store) begin
         mem[wr_index_r] <= scaled;
      end
   end

   // ------------------------------------------------------------------
   // Register writes and host access decode.
   // ------------------------------------------------------------------
   assign host_wr = link.req && link.wr;
   assign host_rd_data = link.req && !link.wr && (link.addr == psf_pkg::ADDR_SAMPLE_BYTE_PORT);

   // Configuration and trim registers.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         config_r <= psf_pkg::RESET_CONFIG;
         trim1_r <= psf_pkg::TRIM_DEFAULT;
         trim2_r <= psf_pkg::TRIM_DEFAULT;
      end else begin
         if (is_write(psf_pkg::ADDR_BUFFER_CONFIG)) begin
            config_r <= {3'h0, link.wdata[4:0]};
         end
         if (is_write(psf_pkg::ADDR_EMITTER1_GAIN_TRIM)) begin
            trim1_r <= link.wdata;
         end
         if (is_write(psf_pkg::ADDR_EMITTER2_GAIN_TRIM)) begin
            trim2_r <= link.wdata;
         end
      end
   end

   // Write index: host write has priority, else advance on store.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         wr_index_r <= psf_pkg::RESET_INDEX;
      end else if (is_write(psf_pkg::ADDR_WRITE_INDEX)) begin
         wr_index_r <= link.wdata[4:0];
      end else if (store) begin
         wr_index_r <= wr_index_r + 5'h01;
      end
   end

   // Read index and byte phase; the third byte read advances the index.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         rd_index_r <= psf_pkg::RESET_INDEX;
         phase_r <= psf_pkg::PH_LOW;
      end else if (is_write(psf_pkg::ADDR_READ_INDEX)) begin
         rd_index_r <= link.wdata[4:0];
         phase_r <= psf_pkg::PH_LOW;
      end else if (host_rd_data) begin
         unique case (phase_r)
            psf_pkg::PH_LOW: begin
               phase_r <= psf_pkg::PH_MID;
            end
            psf_pkg::PH_MID: begin
               phase_r <= psf_pkg::PH_TOP;
            end
            psf_pkg::PH_TOP: begin
               phase_r <= psf_pkg::PH_LOW;
               rd_index_r <= rd_index_r + 5'h01;
            end
         endcase
      end
   end

   // Lost counter: the overwrite event wins over a host clear.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         lost_r <= psf_pkg::RESET_COUNT;
      end else if (overwrite) begin
         if (lost_r != psf_pkg::COUNT_MAX) begin
            lost_r <= lost_r + 4'h1;
         end
      end else if (is_write(psf_pkg::ADDR_LOST_SAMPLE_COUNT)) begin
         lost_r <= link.wdata[3:0];
      end
   end

   // Fill level counts stores less completed sample reads, and an overwrite leaves it; a rewrite of
   // either index clears it to zero and leaves it to the host to keep them consistent.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         level_r <= 6'h00;
      end else if (is_write(psf_pkg::ADDR_WRITE_INDEX) || is_write(psf_pkg::ADDR_READ_INDEX)) begin
         level_r <= 6'h00;
      end else begin
         if (store && !overwrite && !(host_rd_data && phase_r == psf_pkg::PH_TOP && level_r != 6'h00)) begin
            level_r <= level_r + 6'h01;
         end else if (!store && host_rd_data && phase_r == psf_pkg::PH_TOP && level_r != 6'h00) begin
            level_r <= level_r - 6'h01;
         end
      end
   end

   // Almost full compares empty entries with the threshold; zero means full.
   assign empties = (level_r >= 6'h11) ? 4'(psf_pkg::DEPTH_COUNT - level_r) : 4'hf;
   assign almost_full_out = (level_r >= 6'h11) && (empties == config_r[psf_pkg::THRESH_MSB:0]);
   assign fill_level_out = level_r;

   // ------------------------------------------------------------------
   // Read answer: one cycle after the request, the address never moves.
   // ------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         link.ack <= 1'b0;
         link.rdata <= 8'h00;
      end else begin
         link.ack <= link.req;
         if (link.req && !link.wr) begin
            unique case (link.addr)
               psf_pkg::ADDR_BUFFER_CONFIG: link.rdata <= config_r;
               psf_pkg::ADDR_WRITE_INDEX: link.rdata <= {3'h0, wr_index_r};
               psf_pkg::ADDR_READ_INDEX: link.rdata <= {3'h0, rd_index_r};
               psf_pkg::ADDR_LOST_SAMPLE_COUNT: link.rdata <= {4'h0, lost_r};
               psf_pkg::ADDR_SAMPLE_BYTE_PORT: begin
                  unique case (phase_r)
                     psf_pkg::PH_LOW: link.rdata <= mem[rd_index_r][7:0];
                     psf_pkg::PH_MID: link.rdata <= mem[rd_index_r][15:8];
                     psf_pkg::PH_TOP: link.rdata <= {6'h00, mem[rd_index_r][17:16]};
                  endcase
               end
               psf_pkg::ADDR_DEVICE_IDENTITY: link.rdata <= psf_pkg::IDENTITY_VALUE;
               psf_pkg::ADDR_EMITTER1_GAIN_TRIM: link.rdata <= trim1_r;
               psf_pkg::ADDR_EMITTER2_GAIN_TRIM: link.rdata <= trim2_r;
               default: link.rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule : psf_device
`default_nettype wire

// ===== rtl/psf_host.sv
// Host end: turns user commands into single register transfers on the link.
// Assumes the buffer end answers each request with one ack pulse.
`timescale 1ns/10ps
`default_nettype none
module psf_host (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Link to the buffer end.
   psf_link_if.host link,
   // User command port.
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic [7:0] cmd_addr_in,
   input wire logic [7:0] cmd_wdata_in,
   output logic cmd_ready_out,
   output logic resp_valid_out,
   output logic [7:0] resp_data_out
);
   psf_pkg::psf_host_state_type state_r;  // Transfer state.

   // Reserved bits are forced to zero by masking per address.
   function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
      unique case (a)
         psf_pkg::ADDR_BUFFER_CONFIG: clean = {3'h0, d[4:0]};
         psf_pkg::ADDR_WRITE_INDEX: clean = {3'h0, d[4:0]};
         psf_pkg::ADDR_READ_INDEX: clean = {3'h0, d[4:0]};
         psf_pkg::ADDR_LOST_SAMPLE_COUNT: clean = {4'h0, d[3:0]};
         default: clean = d;
      endcase
   endfunction : clean

   assign cmd_ready_out = (state_r == psf_pkg::HS_IDLE);
   assign link.req = (state_r == psf_pkg::HS_REQ);

   // One request at a time; wait for the answer before the next.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         state_r <= psf_pkg::HS_IDLE;
         link.wr <= 1'b0;
         link.addr <= 8'h00;
         link.wdata <= 8'h00;
         resp_valid_out <= 1'b0;
         resp_data_out <= 8'h00;
      end else begin
         resp_valid_out <= 1'b0;
         unique case (state_r)
            psf_pkg::HS_IDLE: begin
               if (cmd_valid_in) begin
                  link.wr <= cmd_write_in;
                  link.addr <= cmd_addr_in;
                  link.wdata <= clean(cmd_addr_in, cmd_wdata_in);
                  state_r <= psf_pkg::HS_REQ;
               end
            end
            psf_pkg::HS_REQ: begin
               state_r <= psf_pkg::HS_WAIT;
            end
            psf_pkg::HS_WAIT: begin
               if (link.ack) begin
                  resp_valid_out <= 1'b1;
                  resp_data_out <= link.rdata;
                  state_r <= psf_pkg::HS_IDLE;
               end
            end
            default: state_r <= psf_pkg::HS_IDLE;
         endcase
      end
   end
endmodule : psf_host
`default_nettype wire

// ===== rtl/psf_link_if.sv
// Interface joining the host end to the sample buffer end.
// Assumes both ends share one clock; register access is a simple request/answer.
`timescale 1ns/10ps
`default_nettype none
interface psf_link_if;
   logic req;          // Host request valid.
   logic wr;           // High for a write request.
   logic [7:0] addr;   // Register address.
   logic [7:0] wdata;  // Write data.
   logic ack;          // Device answer, one-cycle pulse.
   logic [7:0] rdata;  // Read data, valid with ack.
   modport device (input req, wr, addr, wdata, output ack, rdata);
   modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface : psf_link_if
`default_nettype wire

// ===== rtl/psf_pkg.sv
// Package of constants and types shared by both ends of the sample buffer link.
// Assumes a single 100 MHz clock domain and a synchronous active-low reset.
package psf_pkg;
   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_BUFFER_CONFIG = 8'h37;
   localparam logic [7:0] ADDR_WRITE_INDEX = 8'h38;
   localparam logic [7:0] ADDR_READ_INDEX = 8'h39;
   localparam logic [7:0] ADDR_LOST_SAMPLE_COUNT = 8'h3a;
   localparam logic [7:0] ADDR_SAMPLE_BYTE_PORT = 8'h3b;
   localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h3d;
   localparam logic [7:0] ADDR_EMITTER1_GAIN_TRIM = 8'h42;
   localparam logic [7:0] ADDR_EMITTER2_GAIN_TRIM = 8'h43;
   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int ROLLOVER_BIT = 4;
   localparam int THRESH_MSB = 3;
   localparam int INDEX_MSB = 4;
   localparam int COUNT_MSB = 3;
   localparam logic [7:0] RESET_CONFIG = 8'h00;
   localparam logic [4:0] RESET_INDEX = 5'h00;
   localparam logic [3:0] RESET_COUNT = 4'h0;
   localparam logic [3:0] COUNT_MAX = 4'hf;
   // Arbitrary identity and trim defaults, not taken from any part.
   localparam logic [7:0] IDENTITY_VALUE = 8'h5a;
   localparam logic [7:0] TRIM_DEFAULT = 8'h00;
   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int DEPTH = 32;
   localparam int SAMPLE_W = 18;
   localparam logic [5:0] DEPTH_COUNT = 6'h20;
   // Byte phase of the three-byte sample readout.
   typedef enum logic [2:0] {
      PH_LOW = 3'h1,
      PH_MID = 3'h2,
      PH_TOP = 3'h4
   } psf_phase_type;
   // Host transfer state.
   typedef enum logic [2:0] {
      HS_IDLE = 3'h1,
      HS_REQ = 3'h2,
      HS_WAIT = 3'h4
   } psf_host_state_type;
endpackage : psf_pkg

// ===== verification/ppg_sample_fifo_test.sv
// Self-checking bench: host end and buffer end joined by the link interface.
// Assumes the package constants; drives user commands and samples.
`timescale 1ns/10ps
`default_nettype none
module ppg_sample_fifo_test;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, resp_valid;
   logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, resp_data, t, q;
   logic s_valid = 1'b0, s_em2 = 1'b0, dual = 1'b0, s_ready, a_full;
   logic [17:0] s_data = 18'h0, v [36];
   logic [5:0] level;
   logic [7:0] ra [9] = '{8'h37, 8'h38, 8'h39, 8'h3a, 8'h3d, 8'h42, 8'h43, 8'h3c, 8'h3b};
   int bad_count = 0, n_checks = 0;
   psf_link_if psf_link_if_i ();
   psf_device psf_device_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .link(psf_link_if_i),
      .sample_valid_in(s_valid), .sample_data_in(s_data), .sample_emitter2_in(s_em2),
      .sample_ready_out(s_ready), .dual_emitter_mode_in(dual), .almost_full_out(a_full), .fill_level_out(level));
   psf_host psf_host_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .link(psf_link_if_i),
      .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
      .cmd_ready_out(cmd_ready), .resp_valid_out(resp_valid), .resp_data_out(resp_data));
   psf_link_assertions psf_link_assertions_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .req_in(psf_link_if_i.req), .wr_in(psf_link_if_i.wr), .addr_in(psf_link_if_i.addr),
      .wdata_in(psf_link_if_i.wdata), .ack_in(psf_link_if_i.ack), .rdata_in(psf_link_if_i.rdata));
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   // The 100 MHz clock.
   initial begin
      forever #5 clock_in = ~clock_in;
   end
   // Counts and reports one comparison.
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One user command; holds valid until taken, then waits a bounded time for the answer.
   task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock_in);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_wdata <= d;
      do @(posedge clock_in); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do begin @(posedge clock_in); n++; end while (resp_valid !== 1'b1 && n < 10);
      q = resp_data;
      if (n >= 10) bad_count++;
   endtask : reg_op
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      reg_op(1'b0, a, 8'h00);
      check(q, e);
   endtask : rdc
   // Reads one sample from the byte port, which keeps its address across the three reads.
   task automatic rd_sample(input logic [17:0] e);
      rdc(psf_pkg::ADDR_SAMPLE_BYTE_PORT, e[7:0]);
      rdc(psf_pkg::ADDR_SAMPLE_BYTE_PORT, e[15:8]);
      rdc(psf_pkg::ADDR_SAMPLE_BYTE_PORT, {6'h00, e[17:16]});
   endtask : rd_sample
   // Offers one sample and holds it until the buffer takes it.
   task automatic push(input logic [17:0] d, input logic e2);
      @(posedge clock_in);
      s_valid <= 1'b1;
      s_data <= d;
      s_em2 <= e2;
      do @(posedge clock_in); while (s_ready !== 1'b1);
      s_valid <= 1'b0;
   endtask : push
   // Expected stored value: scaled by the trim, clipped to 18 bits.
   function automatic logic [17:0] gain(input logic [17:0] s, input logic [7:0] g);
      logic [26:0] p;
      p = ({9'h0, s} * (27'h100 + {19'h0, g})) >> 8;
      return (p > 27'h3ffff) ? 18'h3ffff : p[17:0];
   endfunction : gain
   task automatic wrap_up;
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // Watchdog against a hang.
   initial begin
      repeat (30000) @(posedge clock_in);
      bad_count++;
      wrap_up();
   end
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(56));
      repeat (16) @(posedge clock_in);
      reset_n_in <= 1'b1;
      // Reset values, identity and an unmapped place.
      for (int i = 0; i < 9; i++) rdc(ra[i], (ra[i] == 8'h3d) ? psf_pkg::IDENTITY_VALUE : 8'h00);
      // Start near the top of the index range: storing begins there and both indices wrap.
      reg_op(1'b1, psf_pkg::ADDR_WRITE_INDEX, 8'h1e);
      reg_op(1'b1, psf_pkg::ADDR_READ_INDEX, 8'h1e);
      for (int i = 0; i < 4; i++) begin v[i] = 18'($urandom); push(v[i], 1'b0); end
      rdc(psf_pkg::ADDR_WRITE_INDEX, 8'h02);
      for (int i = 0; i < 4; i++) rd_sample(v[i]);
      rdc(psf_pkg::ADDR_READ_INDEX, 8'h02);
      reg_op(1'b1, psf_pkg::ADDR_READ_INDEX, 8'h1e);
      rd_sample(v[0]);
      // Emitter 2 samples take their own trim in dual mode; a full-scale value clips.
      // The trim is kept non-zero, so that a random emitter 2 sample really shows the scaling.
      dual <= 1'b1;
      t = 8'($urandom) | 8'h01;
      reg_op(1'b1, psf_pkg::ADDR_EMITTER2_GAIN_TRIM, t);
      rdc(psf_pkg::ADDR_EMITTER2_GAIN_TRIM, t);
      reg_op(1'b1, psf_pkg::ADDR_WRITE_INDEX, 8'h00);
      reg_op(1'b1, psf_pkg::ADDR_READ_INDEX, 8'h00);
      v[0] = 18'h3ffff;
      v[1] = 18'($urandom);
      v[2] = 18'($urandom);
      push(v[0], 1'b1);
      push(v[1], 1'b0);
      push(v[2], 1'b1);
      rd_sample(gain(v[0], t));
      rd_sample(v[1]);
      rd_sample(gain(v[2], t));
      dual <= 1'b0;
      // Back to unity trim, as a host running its own gain loop would leave it.
      reg_op(1'b1, psf_pkg::ADDR_EMITTER2_GAIN_TRIM, 8'h00);
      rdc(psf_pkg::ADDR_EMITTER2_GAIN_TRIM, 8'h00);
      // Fill to the brim with threshold 3, then without rollover one more sample.
      reg_op(1'b1, psf_pkg::ADDR_WRITE_INDEX, 8'h00);
      reg_op(1'b1, psf_pkg::ADDR_READ_INDEX, 8'h00);
      reg_op(1'b1, psf_pkg::ADDR_LOST_SAMPLE_COUNT, 8'h00);
      reg_op(1'b1, psf_pkg::ADDR_BUFFER_CONFIG, 8'h03);
      for (int i = 0; i < 32; i++) begin
         v[i] = 18'($urandom);
         push(v[i], 1'b0);
         repeat (3) @(posedge clock_in);
         if (i == 27 || i == 28) check(a_full, (i == 28));
      end
      reg_op(1'b1, psf_pkg::ADDR_BUFFER_CONFIG, 8'h00);
      check(level, 6'h20);
      check(a_full, 1'b1);
      push(18'($urandom), 1'b0);
      rdc(psf_pkg::ADDR_WRITE_INDEX, 8'h00);
      rd_sample(v[0]);
      // Rollover: one free slot, then sixteen overwrites, counter held at fifteen.
      reg_op(1'b1, psf_pkg::ADDR_BUFFER_CONFIG, 8'h10);
      for (int i = 0; i < 17; i++) begin
         push(18'($urandom), 1'b0);
         if (i == 1) rdc(psf_pkg::ADDR_LOST_SAMPLE_COUNT, 8'h01);
      end
      rdc(psf_pkg::ADDR_WRITE_INDEX, 8'h11);
      rdc(psf_pkg::ADDR_READ_INDEX, 8'h01);
      rdc(psf_pkg::ADDR_LOST_SAMPLE_COUNT, 8'h0f);
      wrap_up();
   end
endmodule : ppg_sample_fifo_test
`default_nettype wire

// ===== verification/psf_link_assertions.sv
// Checker for the register link between the host end and the buffer end.
// Assumes one clock; the bench instantiates it beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module psf_link_assertions (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Link signals.
   input wire logic req_in,
   input wire logic wr_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic ack_in,
   input wire logic [7:0] rdata_in
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // ------------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------------
   logic rd_req; // A read request is on the link.
   logic [1:0] phase_r; // Bytes of the current sample already read.
   assign rd_req = req_in && !wr_in;
   // Mirrors the byte phase, so the top byte can be picked out; a read index write restarts it.
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         phase_r <= 2'h0;
      end else if (req_in && wr_in && addr_in == psf_pkg::ADDR_READ_INDEX) begin
         phase_r <= 2'h0;
      end else if (rd_req && addr_in == psf_pkg::ADDR_SAMPLE_BYTE_PORT) begin
         phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
      end
   end
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   sequence s_top_read;
      rd_req && addr_in == psf_pkg::ADDR_SAMPLE_BYTE_PORT && phase_r == 2'h2;
   endsequence
   sequence s_write;
      req_in && wr_in;
   endsequence
   property p_ack_follows; req_in |=> ack_in; endproperty
   property p_ack_cause; ack_in |-> $past(req_in); endproperty
   property p_ack_single; ack_in |=> !ack_in; endproperty
   property p_req_single; req_in |=> !req_in; endproperty
   property p_top_byte; s_top_read |=> rdata_in[7:2] == 6'h00; endproperty
   property p_rdata_hold; s_write |=> $stable(rdata_in); endproperty
   property p_identity;
      rd_req && addr_in == psf_pkg::ADDR_DEVICE_IDENTITY |=> rdata_in == psf_pkg::IDENTITY_VALUE;
   endproperty
   property p_unmapped; rd_req && addr_in == 8'h3c |=> rdata_in == 8'h00; endproperty
   property p_rd_index_width;
      rd_req && addr_in == psf_pkg::ADDR_READ_INDEX |=> rdata_in[7:5] == 3'h0;
   endproperty
   property p_lost_width;
      rd_req && addr_in == psf_pkg::ADDR_LOST_SAMPLE_COUNT |=> rdata_in[7:4] == 4'h0;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("ack missing after request");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
   a_req_single: assert property (p_req_single) else $error("request longer than one cycle");
   a_top_byte: assert property (p_top_byte) else $error("top sample byte has high bits");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved on a write");
   a_identity: assert property (p_identity) else $error("identity value wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_rd_index_width: assert property (p_rd_index_width) else $error("read index too wide");
   a_lost_width: assert property (p_lost_width) else $error("lost counter too wide");
endmodule : psf_link_assertions
`default_nettype wire
